// *** issue_model.sv ***
`timescale 1ns/10ps
// Decoder and register file stand-in: launches one instruction per call
module issue_model
  import shift_saturate_bitset_pkg::*;
(
  input wire logic i_sys_clk, // CPU clock
  output ssb_issue_t o_issue, // Decoded instruction
  output logic [31:0] o_first_source, // Count or field register
  output logic [39:0] o_second_source // Data operand
);
  initial begin
    o_issue = '0;
    o_first_source = 32'h0;
    o_second_source = 40'h0;
  end

  // Drive just after an edge; the bundle stands for exactly one cycle
  task automatic send(ssb_op_t op, logic w, ci, fi, p, logic [4:0] a, b, d,
                      logic [31:0] f, logic [39:0] s);
    @(posedge i_sys_clk);
    #1;
    o_issue = {1'b1, p, op, w, ci, fi, a, b, d}; // 5-bit immediates
    o_first_source = (op == OP_SETF) ? {22'h0, f[9:0]} : f;
    o_second_source = s;
  endtask : send

  // Released operands flip so stale values are never mistaken for live
  task automatic idle();
    @(posedge i_sys_clk);
    #1;
    o_issue = '0;
    o_first_source = ~o_first_source;
    o_second_source = ~o_second_source;
  endtask : idle
endmodule : issue_model

// *** shift_saturate_bitset_map.svh ***
`ifndef SHIFT_SATURATE_BITSET_MAP_SVH
`define SHIFT_SATURATE_BITSET_MAP_SVH
// Shift count limits
`define SSB_CNT_BITS 6
`define SSB_SHIFT_MAX 6'h28
// Field position layout in the first source register
`define SSB_FEND_LSB 0
`define SSB_FSTART_LSB 5
// Saturation bounds
`define SSB_SAT_MAX 32'h7fffffff
`define SSB_SAT_MIN 32'h80000000
// Reset values
`define SSB_RESULT_RST 40'h0000000000
`endif

// *** shift_saturate_bitset_pkg.sv ***
package shift_saturate_bitset_pkg;
  // Operation select
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_SHL = 4'h1,
    OP_SHRA = 4'h2,
    OP_SHRL = 4'h3,
    OP_SAT = 4'h4,
    OP_SETF = 4'h5
  } ssb_op_t;
  // Issue bundle from the decoder
  typedef struct packed {
    logic valid;
    logic pred_true;
    ssb_op_t op;
    logic wide;
    logic cnt_imm;
    logic fld_imm;
    logic [4:0] imm_a;
    logic [4:0] imm_b;
    logic [4:0] dst_addr;
  } ssb_issue_t;
  // Write-back bundle to the register file
  typedef struct packed {
    logic we;
    logic wide;
    logic [4:0] addr;
    logic [39:0] data;
  } ssb_wb_t;
endpackage : shift_saturate_bitset_pkg

// *** shift_saturate_bitset_unit.sv ***
`timescale 1ns/10ps
`include "shift_saturate_bitset_map.svh"
// Summary of operation
// - Saturate 40-bit value to signed 32 bits
// - Clamp sets saturation flag cycle after write
// - Bit-set forces field start..end to ones
// - Register form: end bits 4:0, start 9:5
// - End below start passes source unchanged
// - Left shift fills zeros, writes destination
// - Register count uses six low bits
// - Counts 40 to 63 act as 40
// - Count bits above bit 5 ignored
// - Arithmetic right shift replicates sign bit
// - Logical right shift fills zeros
module shift_saturate_bitset_unit
  import shift_saturate_bitset_pkg::*;
(
  input wire logic i_sys_clk, // 40 MHz CPU clock
  input wire logic i_rst_b, // Async reset, active low
  input wire ssb_issue_t i_issue, // Decoded instruction
  input wire logic [31:0] i_first_source, // Count or field register
  input wire logic [39:0] i_second_source, // Data operand
  output ssb_wb_t o_wb, // Destination write
  output logic o_saturation_flag // Sticky flag level
);

  ssb_wb_t wb_reg;
  ssb_wb_t wb_next;
  logic sat_pend_reg;
  logic sat_pend_next;
  logic flag_reg;
  logic flag_next;
  logic [39:0] result;
  logic clamped;
  logic [5:0] cnt;
  logic [4:0] f_end;
  logic [4:0] f_start;
  logic fire;

  // Clamp a shift amount to the 40-position ceiling
  function automatic logic [5:0] clamp_cnt(input logic [5:0] c);
    if (c > `SSB_SHIFT_MAX) begin
      return `SSB_SHIFT_MAX;
    end else begin
      return c;
    end
  endfunction : clamp_cnt

  assign fire = i_issue.valid && i_issue.pred_true;

  // Count source: only six low bits reach the shifter
  always_comb begin
    if (i_issue.cnt_imm) begin
      cnt = clamp_cnt({1'b0, i_issue.imm_a});
    end else begin
      cnt = clamp_cnt(i_first_source[5:0]);
    end
  end

  // Field bounds: upper register bits are not checked, result undefined
  always_comb begin
    if (i_issue.fld_imm) begin
      f_start = i_issue.imm_a;
      f_end = i_issue.imm_b;
    end else begin
      f_end = i_first_source[`SSB_FEND_LSB +: 5];
      f_start = i_first_source[`SSB_FSTART_LSB +: 5];
    end
  end

  // Datapath for all operations
  always_comb begin
    logic [31:0] mask;
    logic signed [39:0] s40;
    logic signed [31:0] s32;
    mask = '0;
    s40 = $signed(i_second_source);
    s32 = $signed(i_second_source[31:0]);
    result = '0;
    clamped = 1'b0;
    case (i_issue.op)
      OP_SHL: begin
        result = i_second_source << cnt;
        if (!i_issue.wide) begin
          result[39:32] = 8'h00;
        end
      end
      OP_SHRA: begin
        if (i_issue.wide) begin
          result = 40'(s40 >>> cnt);
        end else begin
          result = {8'h00, 32'(s32 >>> cnt)};
        end
      end
      OP_SHRL: begin
        if (i_issue.wide) begin
          result = i_second_source >> cnt;
        end else begin
          result = {8'h00, 32'({8'h00, i_second_source[31:0]} >> cnt)};
        end
      end
      OP_SAT: begin
        if (s40 > $signed({8'h00, `SSB_SAT_MAX})) begin
          result = {8'h00, `SSB_SAT_MAX};
          clamped = 1'b1;
        end else if (s40 < $signed({8'hff, `SSB_SAT_MIN})) begin
          result = {8'h00, `SSB_SAT_MIN};
          clamped = 1'b1;
        end else begin
          result = {8'h00, i_second_source[31:0]};
        end
      end
      OP_SETF: begin
        for (int i = 0; i < 32; i++) begin
          mask[i] = (5'(i) >= f_start) && (5'(i) <= f_end);
        end
        if (f_end > f_start) begin
          result = {8'h00, i_second_source[31:0] | mask};
        end else begin
          // Equal bounds also take the set path below as a one-bit field
          result = {8'h00, i_second_source[31:0]};
          if (f_end == f_start) begin
            result = {8'h00, i_second_source[31:0] | mask};
          end
        end
      end
      default: result = '0;
    endcase
  end

  // Next write-back and flag state
  always_comb begin
    wb_next.we = fire && (i_issue.op != OP_NONE);
    wb_next.wide = i_issue.wide && (i_issue.op != OP_SAT)
      && (i_issue.op != OP_SETF);
    wb_next.addr = i_issue.dst_addr;
    wb_next.data = result;
    sat_pend_next = fire && (i_issue.op == OP_SAT) && clamped;
    // Flag is sticky; only reset clears it here
    flag_next = flag_reg | sat_pend_reg;
  end

  // Registers
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wb_reg <= '{we: 1'b0, wide: 1'b0, addr: 5'h00,
        data: `SSB_RESULT_RST};
      sat_pend_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      wb_reg <= wb_next;
      sat_pend_reg <= sat_pend_next;
      flag_reg <= flag_next;
    end
  end

  assign o_wb = wb_reg;
  assign o_saturation_flag = flag_reg;

  // Checks on issue look one cycle later, where the registered write-back stands
  a_flag_after_write: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b) sat_pend_reg |-> o_wb.we ##1 o_saturation_flag)
    else $error("saturation flag late");
  a_no_write_false: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b) (i_issue.valid && !i_issue.pred_true)
    |=> !o_wb.we) else $error("write on false predicate");
  a_sat_max_value: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b) (fire && i_issue.op == OP_SAT
    && !i_second_source[39] && i_second_source[38:31] != 8'h00)
    |=> o_wb.data[31:0] == 32'h7fffffff) else $error("sat max");
  a_sat_min_value: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b) (fire && i_issue.op == OP_SAT
    && i_second_source[39] && i_second_source[38:31] != 8'hff)
    |=> o_wb.data[31:0] == 32'h80000000) else $error("sat min");
  a_sat_narrow_result: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b) (fire && i_issue.op == OP_SAT)
    |=> !o_wb.wide && o_wb.data[39:32] == 8'h00) else $error("sat width");
  a_setf_pass_through: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b) (fire && i_issue.op == OP_SETF
    && f_end < f_start) |=> o_wb.data[31:0] == $past(i_second_source[31:0]))
    else $error("bit-set pass failed");
  a_setf_end_bit: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b) (fire && i_issue.op == OP_SETF
    && f_end > f_start) |=> o_wb.data[$past(f_end)]
    && o_wb.data[$past(f_start)]) else $error("field not set");
  // Register form: bounds read straight from the source, not via f_end
  a_setf_reg_bounds: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b) (fire && i_issue.op == OP_SETF
    && !i_issue.fld_imm && i_first_source[4:0] > i_first_source[9:5])
    |=> o_wb.data[$past(i_first_source[4:0])]
    && o_wb.data[$past(i_first_source[9:5])]) else $error("reg bounds");
  a_shl_zero_fill: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b) (fire && i_issue.op == OP_SHL && cnt != 6'h00)
    |=> !o_wb.data[0]) else $error("shl fill");
  a_shl_big_count: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b) (fire && i_issue.op == OP_SHL && i_issue.wide
    && !i_issue.cnt_imm && i_first_source[5:0] >= 6'h28)
    |=> o_wb.data == 40'h0000000000) else $error("shl clamp");
  // A zero count in the six low bits must pass data whatever sits above
  a_count_upper_ignored: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b) (fire && !i_issue.cnt_imm
    && (i_issue.op == OP_SHL || i_issue.op == OP_SHRA
    || i_issue.op == OP_SHRL) && i_first_source[5:0] == 6'h00)
    |=> o_wb.data[31:0] == $past(i_second_source[31:0]))
    else $error("count upper bits used");
  a_shra_sign_fill: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b) (fire && i_issue.op == OP_SHRA && i_issue.wide
    && cnt == 6'h28) |=> o_wb.data == {40{$past(i_second_source[39])}})
    else $error("sign fill");
  a_shra_narrow_sign: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b) (fire && i_issue.op == OP_SHRA && !i_issue.wide)
    |=> o_wb.data[31] == $past(i_second_source[31]))
    else $error("narrow sign");
  // Wide results keep bit 31 live, so only the top bit of the width is zero
  a_shrl_zero_fill: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b) (fire && i_issue.op == OP_SHRL && cnt != 6'h00)
    |=> !o_wb.data[39] && (o_wb.wide || !o_wb.data[31]))
    else $error("zero fill");
  a_issue_to_write: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b) (fire && i_issue.op != OP_NONE) |=> o_wb.we)
    else $error("write not next cycle");
  a_flag_from_clamp: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b) $rose(o_saturation_flag) |-> $past(sat_pend_reg))
    else $error("flag without clamp");

endmodule : shift_saturate_bitset_unit

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
  import shift_saturate_bitset_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  ssb_issue_t iss;
  logic [31:0] fs;
  logic [39:0] ss;
  ssb_wb_t wb;
  logic flag;
  logic flag_exp = 1'b0;
  int error_cnt = 0;
  int check_count = 0;
  logic [46:0] q[$];
  ssb_op_t ops[6] = '{OP_SHL, OP_SHRA, OP_SHRL, OP_SAT, OP_SETF, OP_NONE};

  issue_model pm (.i_sys_clk(i_sys_clk), .o_issue(iss),
                  .o_first_source(fs), .o_second_source(ss));
  shift_saturate_bitset_unit dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .i_issue(iss), .i_first_source(fs), .i_second_source(ss),
    .o_wb(wb), .o_saturation_flag(flag));

  initial forever #12.5 i_sys_clk = ~i_sys_clk;

  task automatic chk(logic [46:0] a, logic [46:0] e);
    check_count++;
    if (a !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, a, e);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // Issue one op and note the expected write-back: {clamp, wide, addr, data}
  task automatic go(ssb_op_t op, logic w, ci, fi, p, logic [4:0] a, b,
                    logic [31:0] f, logic [39:0] s);
    logic [5:0] c;
    logic [4:0] st, en, d;
    logic [39:0] r;
    logic cl;
    d = 5'($urandom);
    c = ci ? {1'b0, a} : f[5:0];
    if (c > 6'h28) c = 6'h28;
    st = fi ? a : f[9:5];
    en = fi ? b : f[4:0];
    cl = 1'b0;
    r = {8'h0, s[31:0]};
    case (op)
      OP_SHL: r = w ? s << c : {8'h0, s[31:0] << c};
      OP_SHRA: begin
        // Separate assignments keep the shift signed in both widths
        if (w) r = $signed(s) >>> c;
        else r = {8'h0, $signed(s[31:0]) >>> c};
      end
      OP_SHRL: r = w ? s >> c : {8'h0, s[31:0] >> c};
      OP_SAT: begin
        cl = $signed(s) > $signed(40'h007fffffff) ||
             $signed(s) < $signed(40'hff80000000);
        if (cl) r = s[39] ? 40'h0080000000 : 40'h007fffffff;
      end
      OP_SETF: begin
        if (en >= st) begin
          for (int i = st; i <= en; i++) r[i] = 1'b1;
        end
      end
      default: ;
    endcase
    pm.send(op, w, ci, fi, p, a, b, d, f, s);
    if (p && op != OP_NONE) q.push_back({cl, w && op < OP_SAT, d, r});
  endtask : go

  // Oldest note is matched to each write; the flag lags a clamp by one cycle
  always @(negedge i_sys_clk) begin : mon
    logic [46:0] e;
    if (i_rst_b) begin
      chk({46'h0, flag}, {46'h0, flag_exp});
      if (wb.we !== 1'b0) begin
        if (q.size() == 0) chk(47'h1, 47'h0);
        else begin
          e = q.pop_front();
          chk({1'b0, wb.wide, wb.addr, wb.data}, {1'b0, e[45:0]});
          flag_exp = flag_exp | e[46];
        end
      end
    end
  end

  initial begin
    #100us;
    error_cnt++;
    close_out();
  end

  initial begin
    logic [31:0] r;
    void'($urandom(32'h87c47ea4));
    repeat (16) @(posedge i_sys_clk);
    #1 i_rst_b = 1'b1;
    go(OP_SAT, 0, 0, 0, 0, 0, 0, 0, 40'h0100000000);
    go(OP_SAT, 0, 0, 0, 1, 0, 0, 0, 40'hff80000000);
    go(OP_SAT, 0, 0, 0, 1, 0, 0, 0, 40'h007fffffff);
    go(OP_SETF, 0, 0, 1, 1, 5'h07, 5'h15, 0, 40'h004b134a1e);
    go(OP_SETF, 0, 0, 0, 1, 0, 0, 32'h197, 40'h009ed31a31);
    go(OP_SETF, 0, 0, 1, 1, 5'h14, 5'h03, 0, 40'h55aa55aa55);
    go(OP_SHRA, 1, 0, 0, 1, 0, 0, 32'hffffffe9, 40'h8000000001);
    go(OP_SHL, 1, 0, 0, 1, 0, 0, 32'hffffffc0, 40'h8123456789);
    go(OP_SAT, 0, 0, 0, 1, 0, 0, 0, 40'h8000000000);
    repeat (300) begin
      r = $urandom;
      go(ops[r % 6], r[3], r[4], r[5], r[8:6] != 3'h0, 5'(r >> 9),
         5'(r >> 14), $urandom, {8'($urandom), 32'($urandom)});
    end
    pm.idle();
    repeat (4) @(posedge i_sys_clk);
    chk(47'(q.size()), 47'h0);
    close_out();
  end
endmodule : tb
